// file: hw/twa_alert_top.v
// Thermal window alert logic with APB registers, fault queues and interrupt.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "twa_map.vh"

module twa_alert_top (
    input  wire        mclk,
    input  wire        rst_b,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Conversion results from the converter on the same clock
    input  wire [12:0] temp_data,
    input  wire        temp_valid,
    // Open-drain window alert pin
    output reg         alert_out,
    output reg         alert_oe,
    // Open-drain critical alarm pin
    output reg         critical_alarm_out,
    output reg         critical_alarm_oe,
    // Interrupt
    output reg         irq
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg [`TWA_CFG_WIDTH-1:0]  config_reg;
    reg [`TWA_TEMP_WIDTH-1:0] hysteresis_amount_reg;
    reg [`TWA_TEMP_WIDTH-1:0] critical_limit_reg;
    reg [`TWA_TEMP_WIDTH-1:0] low_limit_reg;
    reg [`TWA_TEMP_WIDTH-1:0] high_limit_reg;
    reg [`TWA_TEMP_WIDTH-1:0] temp_reg;
    reg [`TWA_IRQ_WIDTH-1:0]  status_reg;
    reg [`TWA_IRQ_WIDTH-1:0]  status_next;
    reg [`TWA_IRQ_WIDTH-1:0]  mask_reg;
    reg                       high_flag_reg;
    reg                       high_flag_next;
    reg                       low_flag_reg;
    reg                       low_flag_next;
    reg                       crit_flag_reg;
    reg                       crit_flag_next;
    reg                       event_alert_reg;
    reg                       event_alert_next;

    wire shutdown   = config_reg[`TWA_CFG_SHUTDOWN];
    wire event_mode = config_reg[`TWA_CFG_EVENT];
    wire queue_en   = config_reg[`TWA_CFG_QUEUE];

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire setup_phase  = psel & ~penable;
    wire access_phase = psel & penable;
    wire wr_access    = access_phase & pwrite;
    wire rd_access    = access_phase & ~pwrite;

    function addr_mapped;
        input [7:0] addr;
        begin
            if (addr == `TWA_OFF_TEMP || addr == `TWA_OFF_CONFIG) begin
                addr_mapped = 1'b1;
            end else if (addr == `TWA_OFF_HYST || addr == `TWA_OFF_CRIT) begin
                addr_mapped = 1'b1;
            end else if (addr == `TWA_OFF_LOW || addr == `TWA_OFF_HIGH) begin
                addr_mapped = 1'b1;
            end else if (addr == `TWA_OFF_STATUS || addr == `TWA_OFF_MASK) begin
                addr_mapped = 1'b1;
            end else begin
                addr_mapped = 1'b0;
            end
        end
    endfunction

    function [31:0] limit_word;
        input [`TWA_TEMP_WIDTH-1:0] value;
        begin
            limit_word = {16'h0000, value, 3'h0};
        end
    endfunction

    reg [31:0] rdata_next;

    always @* begin
        if (paddr == `TWA_OFF_TEMP) begin
            rdata_next = {16'h0000, temp_reg, crit_flag_reg, high_flag_reg, low_flag_reg};
        end else if (paddr == `TWA_OFF_CONFIG) begin
            rdata_next = {27'h0000000, config_reg};
        end else if (paddr == `TWA_OFF_HYST) begin
            rdata_next = limit_word(hysteresis_amount_reg);
        end else if (paddr == `TWA_OFF_CRIT) begin
            rdata_next = limit_word(critical_limit_reg);
        end else if (paddr == `TWA_OFF_LOW) begin
            rdata_next = limit_word(low_limit_reg);
        end else if (paddr == `TWA_OFF_HIGH) begin
            rdata_next = limit_word(high_limit_reg);
        end else if (paddr == `TWA_OFF_STATUS) begin
            rdata_next = {28'h0000000, status_reg};
        end else if (paddr == `TWA_OFF_MASK) begin
            rdata_next = {28'h0000000, mask_reg};
        end else begin
            rdata_next = 32'h00000000;
        end
    end

    // Read data is captured in the setup cycle so the zero-wait access phase sees it stable.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_phase) begin
                prdata  <= rdata_next;
                pslverr <= ~addr_mapped(paddr);
            end
        end
    end

    // Limit and configuration writes; unmapped or read-only targets are ignored.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            config_reg            <= `TWA_CFG_RESET;
            hysteresis_amount_reg <= `TWA_HYST_RESET;
            critical_limit_reg    <= `TWA_CRIT_RESET;
            low_limit_reg         <= `TWA_LOW_RESET;
            high_limit_reg        <= `TWA_HIGH_RESET;
            mask_reg              <= `TWA_MASK_RESET;
        end else if (wr_access) begin
            if (paddr == `TWA_OFF_CONFIG) begin
                config_reg <= pwdata[`TWA_CFG_WIDTH-1:0];
            end else if (paddr == `TWA_OFF_HYST) begin
                hysteresis_amount_reg <= pwdata[15:`TWA_TEMP_LSB];
            end else if (paddr == `TWA_OFF_CRIT) begin
                critical_limit_reg <= pwdata[15:`TWA_TEMP_LSB];
            end else if (paddr == `TWA_OFF_LOW) begin
                low_limit_reg <= pwdata[15:`TWA_TEMP_LSB];
            end else if (paddr == `TWA_OFF_HIGH) begin
                high_limit_reg <= pwdata[15:`TWA_TEMP_LSB];
            end else if (paddr == `TWA_OFF_MASK) begin
                mask_reg <= pwdata[`TWA_IRQ_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Limit comparison
    // ------------------------------------------------------------------------
    // One bit of headroom keeps limit plus or minus hysteresis from wrapping.
    wire signed [13:0] temp_s    = {temp_data[12], temp_data};
    wire signed [13:0] high_s    = {high_limit_reg[12], high_limit_reg};
    wire signed [13:0] low_s     = {low_limit_reg[12], low_limit_reg};
    wire signed [13:0] crit_s    = {critical_limit_reg[12], critical_limit_reg};
    wire signed [13:0] hyst_s    = {hysteresis_amount_reg[12], hysteresis_amount_reg};
    wire signed [13:0] high_rel  = high_s - hyst_s;
    wire signed [13:0] low_rel   = low_s + hyst_s;
    wire signed [13:0] crit_rel  = crit_s - hyst_s;

    wire sample = temp_valid & ~shutdown;
    wire [2:0] fault_vec = {temp_s > crit_s, temp_s < low_s, temp_s > high_s};
    wire [2:0] qual_vec;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_queue
            twa_fault_queue u_queue (
                .mclk      (mclk),
                .rst_b     (rst_b),
                .sample    (sample),
                .fault     (fault_vec[gi]),
                .queue_en  (queue_en),
                .clear     (shutdown),
                .qualified (qual_vec[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Limit flags
    // ------------------------------------------------------------------------
    always @* begin
        high_flag_next = high_flag_reg;
        low_flag_next  = low_flag_reg;
        crit_flag_next = crit_flag_reg;
        if (shutdown) begin
            high_flag_next = 1'b0;
            low_flag_next  = 1'b0;
            crit_flag_next = 1'b0;
        end else if (sample) begin
            if (qual_vec[0]) begin
                high_flag_next = 1'b1;
            end else if (temp_s < high_rel) begin
                high_flag_next = 1'b0;
            end
            if (qual_vec[1]) begin
                low_flag_next = 1'b1;
            end else if (temp_s > low_rel) begin
                low_flag_next = 1'b0;
            end
            if (qual_vec[2]) begin
                crit_flag_next = 1'b1;
            end else if (temp_s < crit_rel) begin
                crit_flag_next = 1'b0;
            end
        end
    end

    wire window_rise   = (high_flag_next & ~high_flag_reg) | (low_flag_next & ~low_flag_reg);
    // Shutdown wipes the flags, which is not a return into the window and must not raise that status bit.
    wire window_return = ~shutdown & (high_flag_reg | low_flag_reg) & ~(high_flag_next | low_flag_next);

    // ------------------------------------------------------------------------
    // Event style latch
    // ------------------------------------------------------------------------
    always @* begin
        event_alert_next = event_alert_reg;
        if (shutdown || !event_mode) begin
            event_alert_next = 1'b0;
        end else if (window_rise || window_return) begin
            event_alert_next = 1'b1;
        end else if (rd_access) begin
            event_alert_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status, write one to clear
    // ------------------------------------------------------------------------
    always @* begin
        status_next = status_reg;
        if (wr_access && paddr == `TWA_OFF_STATUS) begin
            status_next = status_reg & ~pwdata[`TWA_IRQ_WIDTH-1:0];
        end
        // A crossing in the same cycle as its clear is kept.
        if (high_flag_next & ~high_flag_reg) begin
            status_next[`TWA_IRQ_HIGH] = 1'b1;
        end
        if (low_flag_next & ~low_flag_reg) begin
            status_next[`TWA_IRQ_LOW] = 1'b1;
        end
        if (crit_flag_next & ~crit_flag_reg) begin
            status_next[`TWA_IRQ_CRIT] = 1'b1;
        end
        if (window_return) begin
            status_next[`TWA_IRQ_RETURN] = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    // style bit selects comparator or event
    wire alert_active = event_mode ? event_alert_next : (high_flag_next | low_flag_next);

    wire alert_level = alert_active & ~shutdown;
    wire crit_level  = crit_flag_next & ~shutdown;

    // Active low drives the pin when active; active high drives it low when idle.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            high_flag_reg      <= 1'b0;
            low_flag_reg       <= 1'b0;
            crit_flag_reg      <= 1'b0;
            event_alert_reg    <= 1'b0;
            status_reg         <= {`TWA_IRQ_WIDTH{1'b0}};
            temp_reg           <= {`TWA_TEMP_WIDTH{1'b0}};
            alert_out          <= 1'b0;
            alert_oe           <= 1'b0;
            critical_alarm_out <= 1'b0;
            critical_alarm_oe  <= 1'b0;
            irq                <= 1'b0;
        end else begin
            high_flag_reg      <= high_flag_next;
            low_flag_reg       <= low_flag_next;
            crit_flag_reg      <= crit_flag_next;
            event_alert_reg    <= event_alert_next;
            status_reg         <= status_next;
            if (sample) begin
                temp_reg <= temp_data;
            end
            alert_out          <= 1'b0;
            alert_oe           <= alert_level ^ config_reg[`TWA_CFG_ALERT_POL];
            critical_alarm_out <= 1'b0;
            critical_alarm_oe  <= crit_level ^ config_reg[`TWA_CFG_CRIT_POL];
            irq                <= |(status_next & mask_reg);
        end
    end

endmodule
`default_nettype wire

// file: hw/twa_fault_queue.v
// Consecutive fault counter that qualifies one out-of-limit condition.
`timescale 1ns/10ps
`default_nettype none
`include "twa_map.vh"

module twa_fault_queue (
    input  wire mclk,
    input  wire rst_b,
    input  wire sample,
    input  wire fault,
    input  wire queue_en,
    input  wire clear,
    output wire qualified
);

    reg [`TWA_QUEUE_WIDTH-1:0] count_reg;
    reg [`TWA_QUEUE_WIDTH-1:0] count_next;

    assign qualified = sample & fault &
                       (~queue_en | (count_reg == (`TWA_QUEUE_DEPTH - 3'h1)));

    // A clean sample breaks the run; the count saturates so a long fault keeps qualifying.
    always @* begin
        count_next = count_reg;
        if (clear) begin
            count_next = {`TWA_QUEUE_WIDTH{1'b0}};
        end else if (sample) begin
            if (!fault) begin
                count_next = {`TWA_QUEUE_WIDTH{1'b0}};
            end else if (count_reg != (`TWA_QUEUE_DEPTH - 3'h1)) begin
                count_next = count_reg + 3'h1;
            end
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= {`TWA_QUEUE_WIDTH{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

endmodule
`default_nettype wire

// file: hw/twa_map.vh
// Address map, field positions, reset values and counts of the thermal window alert block.
`ifndef TWA_MAP_VH
`define TWA_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TWA_OFF_TEMP    8'h00
`define TWA_OFF_CONFIG  8'h04
`define TWA_OFF_HYST    8'h08
`define TWA_OFF_CRIT    8'h0C
`define TWA_OFF_LOW     8'h10
`define TWA_OFF_HIGH    8'h14
`define TWA_OFF_STATUS  8'h18
`define TWA_OFF_MASK    8'h1C

// ----------------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------------
`define TWA_CFG_SHUTDOWN  0
`define TWA_CFG_EVENT     1
`define TWA_CFG_CRIT_POL  2
`define TWA_CFG_ALERT_POL 3
`define TWA_CFG_QUEUE     4
`define TWA_CFG_WIDTH     5
`define TWA_CFG_RESET     5'h00

// ----------------------------------------------------------------------------
// Temperature word: 13-bit two's complement, 0.0625 degC per count
// ----------------------------------------------------------------------------
`define TWA_TEMP_WIDTH    13
`define TWA_TEMP_LSB      3
`define TWA_HYST_RESET    13'h0020
`define TWA_LOW_RESET     13'h00A0
`define TWA_HIGH_RESET    13'h0400
`define TWA_CRIT_RESET    13'h0590

// ----------------------------------------------------------------------------
// Interrupt status and mask bits
// ----------------------------------------------------------------------------
`define TWA_IRQ_HIGH      0
`define TWA_IRQ_LOW       1
`define TWA_IRQ_CRIT      2
`define TWA_IRQ_RETURN    3
`define TWA_IRQ_WIDTH     4
`define TWA_MASK_RESET    4'h0

// ----------------------------------------------------------------------------
// Fault queue
// ----------------------------------------------------------------------------
`define TWA_QUEUE_DEPTH   3'h4
`define TWA_QUEUE_WIDTH   3

`endif

// file: tb/tb.sv
// Self-checking bench for the thermal window alert block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, temp_valid, irq;
    logic        alert_out, alert_oe, critical_alarm_out, critical_alarm_oe, alert_line, alarm_line;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, ex [8];
    logic [12:0] temp_data;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;
    twa_alert_top u_dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .temp_data, .temp_valid, .alert_out, .alert_oe, .critical_alarm_out, .critical_alarm_oe, .irq);
    twa_pins u_pins (.alert_out, .alert_oe, .critical_alarm_out, .critical_alarm_oe, .alert_line, .alarm_line);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    // ------
    // Shared tasks
    // ------
    task report_and_stop();
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        chk("pslverr", {31'h0, a > 8'h1C}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task conv(input logic [12:0] t);
        @(posedge mclk);
        temp_data <= t;
        temp_valid <= 1'b1;
        @(posedge mclk);
        temp_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // Two edges let a read-clear or a status write reach the registered pins first.
    task pins(input logic a, input logic c);
        repeat (2) @(posedge mclk);
        #1;
        chk("alert_line", {31'h0, a}, {31'h0, alert_line});
        chk("alarm_line", {31'h0, c}, {31'h0, alarm_line});
    endtask
    // ------
    // Scenarios
    // ------
    task t_regs();
        ex = '{32'h0, 32'h0, 32'h100, 32'h2C80, 32'h500, 32'h2000, 32'h0, 32'h0};
        for (int i = 1; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", ex[i], rd);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped read", 32'h0, rd);
    endtask
    task t_window();
        conv(13'h0190);
        pins(1'b1, 1'b1);
        conv(13'h0410);
        pins(1'b0, 1'b1);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h1C, 32'hF);
        apb(1'b0, 8'h1C, 32'h0);
        chk("mask", 32'hF, rd);
        pins(1'b0, 1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b0, 8'h00, 32'h0);
        chk("temp word", {16'h0, 13'h0410, 3'h2}, rd);
        apb(1'b1, 8'h18, 32'h1);
        pins(1'b0, 1'b1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        conv(13'h03D0);
        pins(1'b1, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        chk("status return", 32'h8, rd);
        conv(13'h0090);
        pins(1'b0, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk("low flag", 32'h1, {29'h0, rd[2:0]});
        conv(13'h00D0);
        pins(1'b1, 1'b1);
        apb(1'b1, 8'h18, 32'hF);
    endtask
    task t_event();
        apb(1'b1, 8'h04, 32'h2);
        conv(13'h0410);
        pins(1'b0, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        pins(1'b1, 1'b1);
        apb(1'b1, 8'h14, 32'h2407);
        conv(13'h0410);
        pins(1'b0, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk("high limit", 32'h2400, rd);
        pins(1'b1, 1'b1);
    endtask
    task critical_limit();
        apb(1'b1, 8'h04, 32'h0);
        conv(13'h05A0);
        pins(1'b0, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk("crit flag", 32'h6, {29'h0, rd[2:0]});
        conv(13'h0580);
        pins(1'b0, 1'b0);
        conv(13'h0560);
        pins(1'b0, 1'b1);
        conv(13'h0190);
        pins(1'b1, 1'b1);
    endtask
    task t_queue();
        apb(1'b1, 8'h04, 32'h10);
        for (int i = 0; i < 7; i++) begin
            conv(i == 3 ? 13'h0190 : 13'h0500);
            pins(1'b1, 1'b1);
        end
        conv(13'h0500);
        pins(1'b0, 1'b1);
    endtask
    // Active-high polarity is checked awake too, where idle lines are pulled low by the device.
    task t_shut();
        apb(1'b1, 8'h04, 32'h11);
        pins(1'b1, 1'b1);
        apb(1'b1, 8'h04, 32'h0D);
        conv(13'h05A0);
        pins(1'b0, 1'b0);
        apb(1'b1, 8'h04, 32'h0C);
        conv(13'h05A0);
        pins(1'b1, 1'b1);
        conv(13'h0190);
        pins(1'b0, 1'b0);
        apb(1'b1, 8'h04, 32'h0);
    endtask
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        temp_data = 13'h0000;
        temp_valid = 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_window();
        t_event();
        critical_limit();
        t_queue();
        t_shut();
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: tb/twa_alert_sva.sv
// Assertion checker for the thermal window alert block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module twa_alert_sva (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [12:0] temp_data,
    input wire logic        temp_valid,
    input wire logic        alert_out,
    input wire logic        alert_oe,
    input wire logic        critical_alarm_out,
    input wire logic        critical_alarm_oe,
    input wire logic        irq
);
    // ------
    // Shadow registers
    // ------
    logic [4:0]         cfg_q;
    logic [3:0]         msk_q;
    logic signed [13:0] hys_q;
    logic signed [13:0] crt_q;
    logic signed [13:0] low_q;
    logic signed [13:0] hi_q;
    logic [2:0]         cfg_age;
    wire                wr  = psel && penable && pwrite && pready;
    wire signed [13:0]  tmp = {temp_data[12], temp_data};
    wire signed [13:0]  lim = {pwdata[15], pwdata[15:3]};
    // Queued and shutdown samples are judged by the bench, since their outcome depends on history.
    wire                smp = temp_valid && !cfg_q[0] && !cfg_q[4];
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q   <= 5'h00;
            msk_q   <= 4'h0;
            hys_q   <= 14'h0020;
            crt_q   <= 14'h0590;
            low_q   <= 14'h00A0;
            hi_q    <= 14'h0400;
            cfg_age <= 3'h0;
        end else begin
            if (wr && paddr == 8'h04) cfg_q <= pwdata[4:0];
            if (wr && paddr == 8'h08) hys_q <= lim;
            if (wr && paddr == 8'h0C) crt_q <= lim;
            if (wr && paddr == 8'h10) low_q <= lim;
            if (wr && paddr == 8'h14) hi_q <= lim;
            if (wr && paddr == 8'h1C) msk_q <= pwdata[3:0];
            if (wr && paddr == 8'h04) cfg_age <= 3'h0;
            else if (cfg_age != 3'h7) cfg_age <= cfg_age + 3'h1;
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_ready; $past(rst_b) |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low outside reset");
    property p_slverr; psel && !penable |=> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h1C); endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
    property p_odata; !alert_out && !critical_alarm_out; endproperty
    a_odata: assert property (p_odata) else $error("open-drain data not low");
    property p_high; smp && !cfg_q[1] && tmp > hi_q |-> ##[1:2] alert_oe != cfg_q[3]; endproperty
    a_high: assert property (p_high) else $error("alert not active above upper limit");
    property p_low; smp && !cfg_q[1] && tmp < low_q |-> ##[1:2] alert_oe != cfg_q[3]; endproperty
    a_low: assert property (p_low) else $error("alert not active below lower limit");
    property p_inside;
        smp && !cfg_q[1] && tmp < hi_q - hys_q && tmp > low_q + hys_q |-> ##[1:2] alert_oe == cfg_q[3];
    endproperty
    a_inside: assert property (p_inside) else $error("comparator alert held inside window");
    property p_crit; smp && tmp > crt_q |-> ##[1:2] critical_alarm_oe != cfg_q[2]; endproperty
    a_crit: assert property (p_crit) else $error("critical alarm not active");
    property p_crel; smp && tmp < crt_q - hys_q |-> ##[1:2] critical_alarm_oe == cfg_q[2]; endproperty
    a_crel: assert property (p_crel) else $error("critical alarm not released");
    property p_sdn; cfg_q[0] && cfg_age == 3'h7 |-> alert_oe == cfg_q[3] && critical_alarm_oe == cfg_q[2]; endproperty
    a_sdn: assert property (p_sdn) else $error("outputs active in shutdown");
    // A conversion in the read's own cycle may set the alert again, so only reads without one are judged.
    property p_rdclr;
        cfg_q[1] && !cfg_q[0] && psel && penable && !pwrite && !temp_valid |-> ##[1:2] alert_oe == cfg_q[3];
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("event alert survived a read");
    property p_irq; msk_q == 4'h0 && $past(msk_q) == 4'h0 |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq with all sources masked");
endmodule
bind twa_alert_top twa_alert_sva u_sva (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .temp_data, .temp_valid, .alert_out, .alert_oe, .critical_alarm_out,
    .critical_alarm_oe, .irq);
`default_nettype wire

// file: tb/twa_pins.sv
// Pull-ups on the two open-drain lines as seen by the host and the shutdown circuit.
`timescale 1ns/10ps
`default_nettype none
module twa_pins (
    input  wire logic alert_out,
    input  wire logic alert_oe,
    input  wire logic critical_alarm_out,
    input  wire logic critical_alarm_oe,
    output wire logic alert_line,
    output wire logic alarm_line
);
    // Nothing else drives the lines, so a released pin rises to the pull-up level.
    assign alert_line = alert_oe ? alert_out : 1'b1;
    assign alarm_line = critical_alarm_oe ? critical_alarm_out : 1'b1;
endmodule
`default_nettype wire
